/* verilog/cif_pkg.sv */
// Package for the message interface transfer selector block.
// Assumes a single 25 MHz clock domain and one AHB-Lite slave port.
package cif_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_SELECTOR = 8'h00;
	localparam logic [7:0] OFS_OBJ_REQ  = 8'h04;
	localparam logic [7:0] OFS_BUF_MASK = 8'h08;
	localparam logic [7:0] OFS_BUF_ARB  = 8'h0c;
	localparam logic [7:0] OFS_BUF_CTRL = 8'h10;
	localparam logic [7:0] OFS_BUF_DLO  = 8'h14;
	localparam logic [7:0] OFS_BUF_DHI  = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

	// ----------------------------------------------------------------
	// Selector fields and reset value
	// ----------------------------------------------------------------
	localparam int SEL_PAYLOAD_HI = 0;
	localparam int SEL_PAYLOAD_LO = 1;
	localparam int SEL_FRESH_TX   = 2;
	localparam int SEL_IRQ_CLR    = 3;
	localparam int SEL_CTRL       = 4;
	localparam int SEL_IDENT      = 5;
	localparam int SEL_MASK       = 6;
	localparam int SEL_DIR_WRITE  = 7;
	localparam int SEL_W          = 8;
	localparam logic [SEL_W-1:0] SEL_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Object numbering, control word and status fields
	// ----------------------------------------------------------------
	localparam int OBJ_COUNT = 32;
	localparam int OBJ_AW    = 5;
	localparam int REQ_W     = 6;
	localparam int REQ_BUSY  = 15;
	localparam logic [REQ_W-1:0] REQ_RESET = 6'h01;
	localparam int CTRL_FRESH   = 15;
	localparam int CTRL_IRQ_WAIT = 13;
	localparam int CTRL_TX_REQ  = 8;
	localparam int STAT_DONE    = 0;
	localparam int STAT_FIXED   = 1;
	localparam int STAT_W       = 2;
	localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;
	localparam logic [30:0] MASK_RESET = 31'h7fffffff;

	// ----------------------------------------------------------------
	// Message object carrier
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        extended_filter_enable;
		logic        frame_sense_filter_enable;
		logic [28:0] id_mask;
	} cif_mask_s;

	typedef struct packed {
		logic        object_valid_flag;
		logic        extended_id_flag;
		logic        frame_sense;
		logic [28:0] id;
	} cif_arb_s;

	typedef struct packed {
		cif_mask_s   mask;
		cif_arb_s    identifier_group_select;
		logic [15:0] ctrl;
		logic [31:0] data_hi;
		logic [31:0] data_lo;
	} cif_obj_s;

	localparam int OBJ_W = $bits(cif_obj_s);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_APPLY
	} cif_xfer_state_e;

endpackage

/* verilog/cif_obj_ram.sv */
// Message object store, one object per word, registered read data.
// Assumes the caller never reads and writes the same cycle.
`timescale 1ns/1ps
module cif_obj_ram
	import cif_pkg::*;
(
	// Clock
	input  wire logic                clk,
	// Access
	input  wire logic                rd_en,
	input  wire logic                wr_en,
	input  wire logic [OBJ_AW-1:0]   addr,
	input  wire cif_obj_s            wdata,
	output      cif_obj_s            rdata
);

	cif_obj_s mem [OBJ_COUNT];

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[addr] <= wdata;
		end
		if (rd_en) begin
			rdata <= mem[addr];
		end
	end

endmodule

/* verilog/cif_irq_stat.sv */
// Sticky event status with read-clear and an interrupt mask.
// Assumes event pulses and the clear strobe come from the hclk domain.
`timescale 1ns/1ps
module cif_irq_stat
	import cif_pkg::*;
(
	// Clock and reset
	input  wire logic                hclk,
	input  wire logic                hresetn,
	// Events and software access
	input  wire logic [STAT_W-1:0]   event_p,
	input  wire logic                rd_clear,
	input  wire logic                mask_we,
	input  wire logic [STAT_W-1:0]   mask_wdata,
	// State
	output      logic [STAT_W-1:0]   status_q,
	output      logic [STAT_W-1:0]   mask_q,
	output      logic                irq
);

	// ----------------------------------------------------------------
	// Status, set beats a same-cycle clear
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_q <= STAT_RESET;
		end else begin
			status_q <= (rd_clear ? STAT_RESET : status_q) | event_p;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_q <= STAT_RESET;
		end else if (mask_we) begin
			mask_q <= mask_wdata;
		end
	end

	assign irq = |(status_q & mask_q);

endmodule

/* verilog/cif_xfer_sel.sv */
// Message interface: transfer selector, object request and buffer.
// Assumes a single AHB-Lite master and the hclk domain throughout.
//
// Contract
// - In a read transfer, selector bit 2 set clears the object's fresh-payload flag, else kept.
// - The buffer control word gets the flag values from before any clearing.
// - In a read transfer, selector bit 3 set clears the object's irq-waiting flag, else kept.
// - In a read transfer, selector bit 4 copies the control word into the buffer, else kept.
// - In a read transfer, selector bit 5 copies id, frame sense, extended and valid flags.
// - In a read transfer, selector bit 6 copies the id mask and both filter enables.
// - Selector bit 7 at 0 means read: the requested object is moved into the buffer.
// - All selector flag-clear and group bits reset to 0 and are software read/write.
// - In a read transfer, bits 1 and 0 copy payload bytes 0-3 and 4-7, else kept.
// - An invalid object number is turned into a valid one and that object moves.
`timescale 1ns/1ps
module cif_xfer_sel
	import cif_pkg::*;
(
	// Clock and reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// AHB-Lite slave
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output      logic          hreadyout,
	output      logic          hresp,
	output      logic [31:0]   hrdata,
	// Interrupt
	output      logic          irq
);

	// ----------------------------------------------------------------
	// Bus phase tracking
	// ----------------------------------------------------------------
	logic            ap_valid;
	logic [7:0]      dp_addr_q;
	logic            dp_wr_q;
	logic            dp_rd_q;
	logic            addr_ok_q;

	// Only whole words are used; narrower sizes hit a register only at its word-aligned offset
	assign ap_valid  = hsel && hready && htrans[1];
	assign hreadyout = !dp_rd_q;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_addr_q <= 8'h00;
			dp_wr_q   <= 1'b0;
			dp_rd_q   <= 1'b0;
			addr_ok_q <= 1'b0;
		end else if (ap_valid) begin
			dp_addr_q <= haddr[7:0];
			addr_ok_q <= (haddr[31:8] == 24'h000000) && (hsize <= 3'h2);
			dp_wr_q   <= hwrite;
			dp_rd_q   <= !hwrite;
		end else begin
			dp_wr_q   <= 1'b0;
			dp_rd_q   <= 1'b0;
		end
	end

	// Decoded write strobe for one offset
	function automatic logic wr_hit(input logic [7:0] ofs);
		wr_hit = dp_wr_q && addr_ok_q && (dp_addr_q == ofs);
	endfunction

	// Decoded read strobe for one offset
	function automatic logic rd_hit(input logic [7:0] ofs);
		rd_hit = dp_rd_q && addr_ok_q && (dp_addr_q == ofs);
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	cif_xfer_state_e  state_q;
	logic [SEL_W-1:0] sel_q;
	logic [REQ_W-1:0] req_q;
	logic [OBJ_AW-1:0] idx_q;
	cif_obj_s         buf_q;
	cif_mask_s        buf_mask_q;
	cif_arb_s         buf_arb_q;
	logic [15:0]      buf_ctrl_q;
	logic [31:0]      buf_lo_q;
	logic [31:0]      buf_hi_q;
	logic             apply_rd;
	cif_obj_s         ram_rdata;
	cif_obj_s         ram_wdata;
	logic             busy;
	logic             start;
	logic             req_invalid;
	logic [STAT_W-1:0] events;
	logic [STAT_W-1:0] stat_q;
	logic [STAT_W-1:0] imask_q;
	logic             stat_rd_clr;

	assign busy  = (state_q != ST_IDLE);
	assign start = wr_hit(OFS_OBJ_REQ) && !busy;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_q <= SEL_RESET;
		end else if (wr_hit(OFS_SELECTOR) && !busy) begin
			sel_q <= hwdata[SEL_W-1:0];
		end
	end

	// numbers 0 and above 32 fold onto a valid object
	assign req_invalid = (hwdata[REQ_W-1:0] == 6'h00) || (hwdata[REQ_W-1:0] > 6'h20);

	// the number write is the start trigger
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_q <= REQ_RESET;
		end else if (start) begin
			req_q <= hwdata[REQ_W-1:0];
		end
	end

	// object = low five bits, zero meaning the last one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_q <= '0;
		end else if (start) begin
			idx_q <= hwdata[OBJ_AW-1:0] - 5'h01;
		end
	end

	// ----------------------------------------------------------------
	// Transfer sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					state_q <= ST_APPLY;
				end
				ST_APPLY: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Object written back: merged groups for writes, cleared flags for reads
	always_comb begin
		ram_wdata = ram_rdata;
		if (sel_q[SEL_DIR_WRITE]) begin
			if (sel_q[SEL_CTRL]) begin
				ram_wdata.ctrl = buf_q.ctrl;
			end
			if (sel_q[SEL_IDENT]) begin
				ram_wdata.identifier_group_select = buf_q.identifier_group_select;
			end
			if (sel_q[SEL_MASK]) begin
				ram_wdata.mask = buf_q.mask;
			end
			if (sel_q[SEL_PAYLOAD_LO]) begin
				ram_wdata.data_lo = buf_q.data_lo;
			end
			if (sel_q[SEL_PAYLOAD_HI]) begin
				ram_wdata.data_hi = buf_q.data_hi;
			end
			if (sel_q[SEL_FRESH_TX]) begin
				ram_wdata.ctrl[CTRL_TX_REQ] = 1'b1;
			end
		end else begin
			if (sel_q[SEL_FRESH_TX]) begin
				ram_wdata.ctrl[CTRL_FRESH] = 1'b0;
			end
			if (sel_q[SEL_IRQ_CLR]) begin
				ram_wdata.ctrl[CTRL_IRQ_WAIT] = 1'b0;
			end
		end
	end

	cif_obj_ram u_ram (
		.clk   (hclk),
		.rd_en (state_q == ST_FETCH),
		.wr_en (state_q == ST_APPLY),
		.addr  (idx_q),
		.wdata (ram_wdata),
		.rdata (ram_rdata)
	);

	// ----------------------------------------------------------------
	// Interface buffer
	// ----------------------------------------------------------------
	// read direction fills the buffer from the object
	assign apply_rd = (state_q == ST_APPLY) && !sel_q[SEL_DIR_WRITE];
	assign buf_q    = {buf_mask_q, buf_arb_q, buf_ctrl_q, buf_hi_q, buf_lo_q};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			buf_mask_q <= MASK_RESET;
		end else if (apply_rd && sel_q[SEL_MASK]) begin
			buf_mask_q <= ram_rdata.mask;
		end else if (!busy && wr_hit(OFS_BUF_MASK)) begin
			buf_mask_q <= hwdata[30:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			buf_arb_q <= '0;
		end else if (apply_rd && sel_q[SEL_IDENT]) begin
			buf_arb_q <= ram_rdata.identifier_group_select;
		end else if (!busy && wr_hit(OFS_BUF_ARB)) begin
			buf_arb_q <= hwdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			buf_ctrl_q <= 16'h0000;
		end else if (apply_rd && sel_q[SEL_CTRL]) begin
			// pre-clear flag values taken from the fetched word
			buf_ctrl_q <= ram_rdata.ctrl;
		end else if (!busy && wr_hit(OFS_BUF_CTRL)) begin
			buf_ctrl_q <= hwdata[15:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			buf_lo_q <= 32'h00000000;
		end else if (apply_rd && sel_q[SEL_PAYLOAD_LO]) begin
			buf_lo_q <= ram_rdata.data_lo;
		end else if (!busy && wr_hit(OFS_BUF_DLO)) begin
			buf_lo_q <= hwdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			buf_hi_q <= 32'h00000000;
		end else if (apply_rd && sel_q[SEL_PAYLOAD_HI]) begin
			buf_hi_q <= ram_rdata.data_hi;
		end else if (!busy && wr_hit(OFS_BUF_DHI)) begin
			buf_hi_q <= hwdata;
		end
	end

	// ----------------------------------------------------------------
	// Events and interrupt
	// ----------------------------------------------------------------
	logic fixed_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fixed_q <= 1'b0;
		end else if (start) begin
			fixed_q <= req_invalid;
		end
	end

	always_comb begin
		events             = STAT_RESET;
		events[STAT_DONE]  = (state_q == ST_APPLY);
		events[STAT_FIXED] = (state_q == ST_APPLY) && fixed_q;
	end

	assign stat_rd_clr = rd_hit(OFS_IRQ_STAT);

	cif_irq_stat u_irq (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.event_p    (events),
		.rd_clear   (stat_rd_clr),
		.mask_we    (wr_hit(OFS_IRQ_MASK)),
		.mask_wdata (hwdata[STAT_W-1:0]),
		.status_q   (stat_q),
		.mask_q     (imask_q),
		.irq        (irq)
	);

	// ----------------------------------------------------------------
	// Read data, one wait state
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;

	// Reading during the wait state keeps a same-edge write visible
	always_comb begin
		rd_mux = 32'h00000000;
		if (!addr_ok_q) begin
			rd_mux = 32'h00000000;
		end else if (dp_addr_q == OFS_SELECTOR) begin
			rd_mux[SEL_W-1:0] = sel_q;
		end else if (dp_addr_q == OFS_OBJ_REQ) begin
			rd_mux[REQ_W-1:0] = req_q;
			rd_mux[REQ_BUSY]  = busy;
		end else if (dp_addr_q == OFS_BUF_MASK) begin
			rd_mux[30:0] = buf_q.mask;
		end else if (dp_addr_q == OFS_BUF_ARB) begin
			rd_mux = buf_q.identifier_group_select;
		end else if (dp_addr_q == OFS_BUF_CTRL) begin
			rd_mux[15:0] = buf_q.ctrl;
		end else if (dp_addr_q == OFS_BUF_DLO) begin
			rd_mux = buf_q.data_lo;
		end else if (dp_addr_q == OFS_BUF_DHI) begin
			rd_mux = buf_q.data_hi;
		end else if (dp_addr_q == OFS_IRQ_STAT) begin
			rd_mux[STAT_W-1:0] = stat_q;
		end else if (dp_addr_q == OFS_IRQ_MASK) begin
			rd_mux[STAT_W-1:0] = imask_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (dp_rd_q) begin
			hrdata <= rd_mux;
		end
	end

endmodule

/* testbench/cif_xfer_sel_props.sv */
// Checker for the transfer selector block, bound to its top module.
// Assumes hready is hreadyout fed back and word accesses only.
`timescale 1ns/1ps
module cif_xfer_sel_props
	import cif_pkg::*;
(
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic       take;
	logic       rd_q, wr_q, bad_q, msk_q;
	logic [7:0] a_q, sel_q;
	logic [2:0] cnt_q;
	assign take = hsel && hready && htrans[1];
	// ----------
	// Data phase
	// ----------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			bad_q <= 1'b0;
			a_q <= 8'h00;
		end else if (hready) begin
			rd_q <= take && !hwrite;
			wr_q <= take && hwrite;
			bad_q <= (|haddr[31:8]) || hsize > 3'h2;
			a_q <= haddr[7:0];
		end
	end
	// Shadows; selector writes while busy are never issued by the bench
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_q <= SEL_RESET;
			msk_q <= 1'b0;
		end else if (wr_q && hready && !bad_q) begin
			if (a_q == OFS_SELECTOR)
				sel_q <= hwdata[7:0];
			if (a_q == OFS_IRQ_MASK)
				msk_q <= |hwdata[STAT_W-1:0];
		end
	end
	// Transfer still running, done event lands three edges after start
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cnt_q <= 3'd0;
		else if (take && hwrite && haddr == {24'h0, OFS_OBJ_REQ})
			cnt_q <= 3'd5;
		else if (cnt_q != 3'd0)
			cnt_q <= cnt_q - 3'd1;
	end
	// ----------
	// Properties
	// ----------
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	write_nowait_a: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	sel_readback_a: assert property (
		rd_q && hreadyout && !bad_q && a_q == OFS_SELECTOR |-> hrdata == {24'h0, sel_q})
		else $error("selector readback wrong");
	unmapped_zero_a: assert property (rd_q && hreadyout && bad_q |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	stat_clear_a: assert property (take && !hwrite && haddr == {24'h0, OFS_IRQ_STAT}
		&& cnt_q == 3'd0 |=> ##1 !irq)
		else $error("status read did not clear irq");
	irq_masked_a: assert property (!msk_q |-> !irq)
		else $error("irq with mask clear");
	rdata_hold_a: assert property ($changed(hrdata) |-> $past(rd_q && !hreadyout))
		else $error("read data changed outside wait");
endmodule

bind cif_xfer_sel cif_xfer_sel_props cif_xfer_sel_props_i (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .irq(irq));

/* testbench/cif_xfer_sel_tb_top.sv */
// Self-checking bench for the transfer selector block over AHB-Lite.
// Assumes one slave with hready looped back; checker bound elsewhere.
`timescale 1ns/1ps
module cif_xfer_sel_tb_top
	import cif_pkg::*;
;
	typedef struct packed {logic [31:0] a, e, m;} cif_note_s;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd_v, hrdata;
	logic [1:0]  htrans = 2'b00;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, irq, dph = 1'b0;
	logic [31:0] rng = 32'd33578;
	logic [31:0] obj[5];
	int          sel_bit[5] = '{6, 5, 4, 1, 0};
	int          fails = 0, num_checks = 0;
	cif_note_s   notes[$];
	always #20 hclk = ~hclk;
	cif_xfer_sel cif_xfer_sel_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
	// ----------
	// Helpers
	// ----------
	function automatic logic [31:0] nxt();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic [31:0] ad(logic [7:0] o);
		return {24'h0, o};
	endfunction
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Sampled at the negedge, so the rising edge sees the same values
	task automatic wait_rdy(output logic [31:0] d);
		int n;
		logic r;
		for (n = 0; n < 50; n++) begin
			@(negedge hclk);
			r = hreadyout;
			d = hrdata;
			@(posedge hclk);
			if (r)
				break;
		end
		if (n == 50) begin
			fails++;
			wrap_up();
		end
	endtask
	task automatic xfer(logic w, logic [31:0] a, logic [31:0] wd, output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		wait_rdy(d);
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy(d);
	endtask
	task automatic wr(logic [31:0] a, logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, a, d, x);
	endtask
	task automatic rd(logic [31:0] a, logic [31:0] e, logic [31:0] m = 32'hffffffff);
		notes.push_back('{a, e, m});
		xfer(1'b0, a, 32'h0, rd_v);
	endtask
	task automatic start(logic [31:0] num);
		int n;
		wr(ad(OFS_OBJ_REQ), num);
		for (n = 0; n < 20; n++) begin
			rd(ad(OFS_OBJ_REQ), 32'h0, 32'h0);
			if (!rd_v[REQ_BUSY])
				break;
		end
		if (n == 20) begin
			fails++;
			wrap_up();
		end
	endtask
	// ----------
	// Read monitor
	// ----------
	always @(negedge hclk) begin
		cif_note_s n;
		if (hreadyout) begin
			if (dph && notes.size() == 0)
				check("spare read", 32'h1, 32'h0);
			else if (dph) begin
				n = notes.pop_front();
				if (n.m != 32'h0)
					check($sformatf("rd %h", n.a), hrdata & n.m, n.e & n.m);
			end
			dph = hsel && htrans[1] && !hwrite;
		end
	end
	// ----------
	// Scenarios
	// ----------
	initial begin
		int k, g;
		logic [31:0] c;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(ad(OFS_SELECTOR), 32'h0);
		rd(ad(OFS_OBJ_REQ), 32'h1);
		rd(ad(OFS_BUF_MASK), {1'b0, MASK_RESET});
		rd(ad(OFS_IRQ_STAT), 32'h0);
		rd(32'h100, 32'h0);
		$display("reset test done");
		for (k = 0; k < 4; k++) begin
			c = nxt();
			wr(ad(OFS_SELECTOR), c);
			rd(ad(OFS_SELECTOR), {24'h0, c[7:0]});
		end
		$display("selector test done");
		// Object 5 gets both flags set, only low control bits random
		for (k = 0; k < 5; k++)
			obj[k] = nxt();
		obj[0][31] = 1'b0;
		obj[2] = 32'ha000 | (obj[2] & 32'hf);
		for (k = 0; k < 5; k++)
			wr(ad(OFS_BUF_MASK + 8'(4 * k)), obj[k]);
		wr(ad(OFS_SELECTOR), 32'hf3);
		start(32'd5);
		for (g = 0; g < 5; g++) begin
			for (k = 0; k < 5; k++)
				wr(ad(OFS_BUF_MASK + 8'(4 * k)), 32'h0);
			wr(ad(OFS_SELECTOR), 32'h1 << sel_bit[g]);
			start(32'd5);
			for (k = 0; k < 5; k++)
				rd(ad(OFS_BUF_MASK + 8'(4 * k)), k == g ? obj[k] : 32'h0);
		end
		$display("group test done");
		wr(ad(OFS_SELECTOR), 32'h14);
		start(32'd5);
		rd(ad(OFS_BUF_CTRL), obj[2]);
		wr(ad(OFS_SELECTOR), 32'h18);
		start(32'd5);
		rd(ad(OFS_BUF_CTRL), obj[2] & ~32'h8000);
		wr(ad(OFS_SELECTOR), 32'h10);
		start(32'd5);
		rd(ad(OFS_BUF_CTRL), obj[2] & ~32'ha000);
		$display("flag test done");
		// Write direction with bit 2 raises the object's tx request
		wr(ad(OFS_BUF_CTRL), 32'h0);
		wr(ad(OFS_SELECTOR), 32'h94);
		start(32'd5);
		wr(ad(OFS_SELECTOR), 32'h10);
		start(32'd5);
		rd(ad(OFS_BUF_CTRL), 32'h100);
		$display("tx request test done");
		c = nxt();
		wr(ad(OFS_BUF_DLO), c);
		wr(ad(OFS_SELECTOR), 32'h82);
		start(32'd32);
		wr(ad(OFS_BUF_DLO), 32'h0);
		rd(ad(OFS_IRQ_STAT), 32'h0, 32'h0);
		wr(ad(OFS_IRQ_MASK), 32'h3);
		wr(ad(OFS_SELECTOR), 32'h02);
		start(32'h0);
		check("irq", {31'h0, irq}, 32'h1);
		rd(ad(OFS_BUF_DLO), c);
		rd(ad(OFS_IRQ_STAT), 32'h3);
		check("irq", {31'h0, irq}, 32'h0);
		wr(ad(OFS_IRQ_MASK), 32'h2);
		start(32'd5);
		check("irq", {31'h0, irq}, 32'h0);
		rd(ad(OFS_IRQ_STAT), 32'h1);
		$display("irq test done");
		repeat (4) @(posedge hclk);
		check("notes left", notes.size(), 32'h0);
		wrap_up();
	end
endmodule
